// File: core/rpmc_pkg.sv
// rail power-mode control: shared constants, states and timing counts
// assumes a single 50 MHz clock and synchronous active-high reset
package rpmc_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_KHZ       = 50000;   // mclk rate in kHz
  localparam int T_RAIL3_MS    = 2;       // rail_3 delay after rail_2 power-ok
  localparam int T_RAIL1_MS    = 4;       // rail_1 delay after rail_2 power-ok
  localparam int T_RAIL5_MS    = 8;       // rail_5 delay after rail_2 power-ok
  localparam int T_RST_MS      = 64;      // reset time-out, plain default
  localparam int RAIL3_CYC_DEF = T_RAIL3_MS * CLK_KHZ;
  localparam int RAIL1_CYC_DEF = T_RAIL1_MS * CLK_KHZ;
  localparam int RAIL5_CYC_DEF = T_RAIL5_MS * CLK_KHZ;
  localparam int RST_CYC_DEF   = T_RST_MS * CLK_KHZ;
  localparam int CNT_W         = 23;      // holds the longest count

  // ***********************************************************
  // rail vector layout, index 1..7
  // ***********************************************************
  localparam logic [7:1] RAILS_OFF    = 7'h00;
  localparam logic [7:1] RAILS_HIB    = 7'h01;
  localparam logic [7:1] RAILS_NORMAL = 7'h1F;
  localparam logic [7:1] RAILS_ALL    = 7'h7F;

  // ***********************************************************
  // power-mode states
  // ***********************************************************
  typedef enum logic [3:0] {
    S_OFF   = 4'h1,
    S_START = 4'h2,
    S_ON    = 4'h4,
    S_HIB   = 4'h8
  } rpmc_state_t;

endpackage : rpmc_pkg

// File: core/rpmc_timer.sv
// rail power-mode control: saturating up-counter with synchronous clear
// assumes clr is synchronous to mclk
`timescale 1ns/1ps
module rpmc_timer
  import rpmc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clr,
  output logic [CNT_W-1:0]      count
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // saturates so a long-held condition never wraps back below a threshold
  assign count_next = clr ? '0 : ((&count_reg) ? count_reg : count_reg + 1'b1);
  assign count      = count_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : rpmc_timer

// File: core/rpmc_rail_power_mode_control.sv
// rail power-mode control: decides which of seven rails are on
// assumes all inputs synchronous to mclk; open-drain outputs need pull-ups
`timescale 1ns/1ps
module rpmc_rail_power_mode_control
  import rpmc_pkg::*;
#(
  parameter int RAIL3_CYC = RAIL3_CYC_DEF,
  parameter int RAIL1_CYC = RAIL1_CYC_DEF,
  parameter int RAIL5_CYC = RAIL5_CYC_DEF,
  parameter int RST_CYC   = RST_CYC_DEF
) (
  input  wire logic  mclk,
  input  wire logic  sys_rst,
  input  wire logic  power_hold_in,
  input  wire logic  hibernate_request_n,
  input  wire logic  pushbutton_in_n,
  input  wire logic  manual_reset_in_n,
  input  wire logic  force_first_rail_on,
  input  wire logic  aux6_enable,
  input  wire logic  aux7_enable,
  input  wire logic  rail2_power_ok,
  input  wire logic  irq_event,
  input  wire logic  voltage_select_in,
  output logic       voltage_select_level,
  output logic       rail_1,
  output logic       rail_2,
  output logic       rail_3,
  output logic       rail_4,
  output logic       rail_5,
  output logic       rail_6,
  output logic       rail_7,
  output logic       reset_out_n_o,
  output logic       reset_out_n_oe_n,
  output logic       interrupt_out_n_o,
  output logic       interrupt_out_n_oe_n,
  output logic       button_state_out_n_o,
  output logic       button_state_out_n_oe_n,
  output logic       sys_mode_on
);

  // ***********************************************************
  // state and timers
  // ***********************************************************
  rpmc_state_t      state_reg;
  rpmc_state_t      state_next;
  logic             wake_reg;
  logic             wake_next;
  logic [7:1]       rail_reg;
  logic [7:1]       rail_next;
  logic             rst_drive_reg;
  logic             irq_drive_reg;
  logic             btn_drive_reg;
  logic             volt_sel_reg;
  logic [CNT_W-1:0] seq_count;
  logic [CNT_W-1:0] rst_count;

  wire held        = power_hold_in & hibernate_request_n;
  wire btn_pressed = ~pushbutton_in_n;
  wire seq_clr     = (state_reg != S_START) | ~rail2_power_ok;
  wire rst_clr     = (state_reg == S_OFF) | ~rail2_power_ok | ~manual_reset_in_n;
  wire rst_done    = rst_count >= CNT_W'(RST_CYC);
  wire r3_due      = seq_count >= CNT_W'(RAIL3_CYC);
  wire r1_due      = seq_count >= CNT_W'(RAIL1_CYC);
  wire r5_due      = seq_count >= CNT_W'(RAIL5_CYC);

  rpmc_timer u_seq_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clr     (seq_clr),
    .count   (seq_count)
  );

  rpmc_timer u_rst_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clr     (rst_clr),
    .count   (rst_count)
  );

  // ***********************************************************
  // mode sequencing
  // ***********************************************************
  always_comb begin
    state_next = state_reg;
    wake_next  = wake_reg;
    case (state_reg)
      S_OFF: begin
        wake_next = 1'b0;
        if (btn_pressed) begin
          state_next = S_START;
        end
      end
      S_START: begin
        // processor must have taken control before release
        if (!btn_pressed) begin
          state_next = held ? S_ON : S_OFF;
        end
      end
      S_ON: begin
        wake_next = 1'b0;
        if (!power_hold_in) begin
          state_next = S_OFF;
        end else if (!hibernate_request_n) begin
          state_next = force_first_rail_on ? S_HIB : S_OFF;
        end
      end
      S_HIB: begin
        if (!power_hold_in) begin
          state_next = S_OFF;
        end else if (btn_pressed) begin
          state_next = S_START;
          wake_next  = 1'b1;
        end
      end
      default: begin
        state_next = S_OFF;
        wake_next  = 1'b0;
      end
    endcase
  end

  // ***********************************************************
  // rail enables
  // ***********************************************************
  // rail_1 stays up through a wake so hibernate memory is kept
  wire [7:1] rails_start = {2'b00, r5_due, rail2_power_ok, r3_due, 1'b1,
                            r1_due | wake_reg};
  wire [7:1] rails_on    = {aux7_enable, aux6_enable, 5'h1F};

  assign rail_next = (state_reg == S_START) ? rails_start :
                     (state_reg == S_ON)    ? rails_on    :
                     (state_reg == S_HIB)   ? RAILS_HIB   : RAILS_OFF;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg     <= S_OFF;
      wake_reg      <= 1'b0;
      rail_reg      <= RAILS_OFF;
      rst_drive_reg <= 1'b1;
      irq_drive_reg <= 1'b0;
      btn_drive_reg <= 1'b0;
      volt_sel_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      wake_reg      <= wake_next;
      rail_reg      <= rail_next;
      rst_drive_reg <= ~rst_done;
      irq_drive_reg <= irq_event;
      btn_drive_reg <= btn_pressed;
      volt_sel_reg  <= voltage_select_in;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign {rail_7, rail_6, rail_5, rail_4, rail_3, rail_2, rail_1} = rail_reg;
  assign voltage_select_level    = volt_sel_reg;
  assign sys_mode_on             = (state_reg == S_ON);
  // open-drain: data is always low, enable low pulls the wire
  assign reset_out_n_o           = 1'b0;
  assign reset_out_n_oe_n        = ~rst_drive_reg;
  assign interrupt_out_n_o       = 1'b0;
  assign interrupt_out_n_oe_n    = ~irq_drive_reg;
  assign button_state_out_n_o    = 1'b0;
  assign button_state_out_n_oe_n = ~btn_drive_reg;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_all_on;
    (state_reg == S_ON && aux6_enable && aux7_enable) |=> rail_reg == RAILS_ALL;
  endproperty
  a_all_on: assert property (p_all_on) else $error("all-on mode not all rails");

  property p_normal;
    (state_reg == S_ON && !aux6_enable && !aux7_enable) |=> rail_reg == RAILS_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode rails wrong");

  property p_hib_entry;
    (state_reg == S_ON && power_hold_in && !hibernate_request_n && force_first_rail_on)
      |=> (state_reg == S_HIB) ##1 (rail_reg == RAILS_HIB);
  endproperty
  a_hib_entry: assert property (p_hib_entry) else $error("hibernate rails wrong");

  property p_hold_drop;
    (state_reg == S_ON && !power_hold_in) |=> ##1 rail_reg == RAILS_OFF;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("rails not off on hold drop");

  property p_button_start;
    (state_reg == S_OFF && btn_pressed) |=> ##1 (rail_reg[2] && !rail_reg[6] && !rail_reg[7]);
  endproperty
  a_button_start: assert property (p_button_start) else $error("button did not start");

  property p_hib_gate;
    (state_reg == S_ON && power_hold_in && !hibernate_request_n && !force_first_rail_on)
      |=> ##1 rail_reg[5:2] == 4'h0;
  endproperty
  a_hib_gate: assert property (p_hib_gate) else $error("rails 2-5 not gated off");

  property p_irq;
    irq_event |=> !interrupt_out_n_oe_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not driven");

  property p_abort;
    (state_reg == S_START && !btn_pressed && !held) |=> (state_reg == S_OFF) ##1 !(|rail_reg);
  endproperty
  a_abort: assert property (p_abort) else $error("start-up not aborted");

  property p_rail1_wait;
    (state_reg == S_START && !wake_reg && seq_count < CNT_W'(RAIL1_CYC)) |=> !rail_reg[1];
  endproperty
  a_rail1_wait: assert property (p_rail1_wait) else $error("rail_1 enabled early");

  property p_manual_reset;
    !manual_reset_in_n |=> ##1 !reset_out_n_oe_n [*2];
  endproperty
  a_manual_reset: assert property (p_manual_reset) else $error("manual reset not held");

  property p_button_state;
    btn_pressed ##1 btn_pressed |-> !button_state_out_n_oe_n;
  endproperty
  a_button_state: assert property (p_button_state) else $error("button state not low");

  property p_aux_gate;
    (state_reg != S_ON) |=> !rail_reg[6] && !rail_reg[7];
  endproperty
  a_aux_gate: assert property (p_aux_gate) else $error("aux rail on outside on mode");

  c_reach_on:  cover property (state_reg == S_START ##1 state_reg == S_ON);
  c_reach_hib: cover property (state_reg == S_ON ##1 state_reg == S_HIB);
  c_abort:     cover property (state_reg == S_START ##1 state_reg == S_OFF);
  c_wake:      cover property (state_reg == S_HIB ##1 state_reg == S_START);

endmodule : rpmc_rail_power_mode_control

// File: testbench/rpmc_proc_model.sv
// processor model: drives the hold and hibernate lines from software intent
// assumes reset_line is the resolved open-drain reset wire
`timescale 1ns/1ps
module rpmc_proc_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic reset_line,
  input  wire logic take,
  input  wire logic hib_cmd,
  output logic      power_hold_in,
  output logic      hibernate_request_n
);
  logic booted;
  // once out of reset, software keeps control until told to let go
  assign booted = power_hold_in | reset_line;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      power_hold_in       <= 1'b0;
      hibernate_request_n <= 1'b0;
    end else begin
      power_hold_in       <= take & booted;
      hibernate_request_n <= take & booted & !hib_cmd;
    end
  end
endmodule : rpmc_proc_model

// File: testbench/rpmc_rail_power_mode_control_bench.sv
// bench: drives control levels, checks rails and open-drain lines
// assumes shortened timing parameters so a start sequence is short
`timescale 1ns/1ps
module rpmc_rail_power_mode_control_bench;
  import rpmc_pkg::*;
  logic       mclk, sys_rst, pb_n, mr_n, frc, aux6, aux7, pok, irq, volt_sel, take, hib_cmd;
  logic       hold, hib_n, volt_sel_lvl, rst_o, rst_oe_n, int_oe_n, bs_oe_n, rst_line, mode_on;
  logic [7:1] rails;
  int         n_mismatch, comparisons, cycles;
  assign rst_line = rst_oe_n ? 1'b1 : rst_o;
  rpmc_rail_power_mode_control #(.RAIL3_CYC(20), .RAIL1_CYC(40), .RAIL5_CYC(80),
    .RST_CYC(100)) rpmc_rail_power_mode_control_i (
    .mclk(mclk), .sys_rst(sys_rst), .power_hold_in(hold), .hibernate_request_n(hib_n),
    .pushbutton_in_n(pb_n), .manual_reset_in_n(mr_n), .force_first_rail_on(frc),
    .aux6_enable(aux6), .aux7_enable(aux7), .rail2_power_ok(pok), .irq_event(irq),
    .voltage_select_in(volt_sel), .voltage_select_level(volt_sel_lvl), .rail_1(rails[1]),
    .rail_2(rails[2]), .rail_3(rails[3]), .rail_4(rails[4]), .rail_5(rails[5]),
    .rail_6(rails[6]), .rail_7(rails[7]), .reset_out_n_o(rst_o),
    .reset_out_n_oe_n(rst_oe_n), .interrupt_out_n_o(), .interrupt_out_n_oe_n(int_oe_n),
    .button_state_out_n_o(), .button_state_out_n_oe_n(bs_oe_n), .sys_mode_on(mode_on));
  rpmc_proc_model rpmc_proc_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .reset_line(rst_line), .take(take),
    .hib_cmd(hib_cmd), .power_hold_in(hold), .hibernate_request_n(hib_n));
  // ***************************************************
  // helpers
  // ***************************************************
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    @(negedge mclk);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
    // return on a rising edge so the next stimulus lands there
    @(posedge mclk);
  endtask : chk
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // a hang past the expected run length is counted and closes the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ***************************************************
  // scenarios
  // ***************************************************
  initial begin
    {pb_n, mr_n, sys_rst} <= 3'h7;
    {frc, aux6, aux7, pok, irq, volt_sel, take, hib_cmd} <= 8'h00;
    w(8);
    sys_rst <= 1'b0;
    chk("off", rails, 8'h00);
    pb_n <= 1'b0;
    w(4);
    chk("start", rails, 8'h02);
    chk("button state", bs_oe_n, 8'h00);
    pok <= 1'b1;
    w(3);
    chk("rail4 at ok", rails, 8'h0A);
    chk("reset held", rst_oe_n, 8'h00);
    w(25);
    chk("rail3", rails, 8'h0E);
    w(20);
    chk("rail1", rails, 8'h0F);
    w(40);
    chk("rail5", rails, 8'h1F);
    chk("reset before timeout", rst_oe_n, 8'h00);
    w(20);
    chk("reset freed", rst_oe_n, 8'h01);
    take <= 1'b1;
    w(3);
    pb_n <= 1'b1;
    aux6 <= 1'b1;
    aux7 <= 1'b1;
    w(4);
    chk("all on", rails, 8'h7F);
    chk("mode on", mode_on, 8'h01);
    chk("button free", bs_oe_n, 8'h01);
    aux6 <= 1'b0;
    aux7 <= 1'b0;
    irq <= 1'b1;
    volt_sel <= 1'b1;
    w(3);
    chk("normal", rails, 8'h1F);
    chk("interrupt", int_oe_n, 8'h00);
    chk("voltage select", volt_sel_lvl, 8'h01);
    // rail_2 is off in hibernate, so its power-ok drops with it
    frc <= 1'b1;
    hib_cmd <= 1'b1;
    pok <= 1'b0;
    irq <= 1'b0;
    w(4);
    chk("hibernate", rails, 8'h01);
    chk("reset in hibernate", rst_oe_n, 8'h00);
    chk("interrupt free", int_oe_n, 8'h01);
    pb_n <= 1'b0;
    pok <= 1'b1;
    w(4);
    chk("wake", rails & 7'h03, 8'h03);
    hib_cmd <= 1'b0;
    w(2);
    pb_n <= 1'b1;
    w(4);
    chk("rewoken", rails, 8'h1F);
    chk("wake reset held", rst_oe_n, 8'h00);
    w(100);
    chk("wake reset freed", rst_oe_n, 8'h01);
    mr_n <= 1'b0;
    w(3);
    chk("manual reset", rst_oe_n, 8'h00);
    mr_n <= 1'b1;
    w(90);
    chk("reset after release", rst_oe_n, 8'h00);
    w(20);
    chk("manual reset freed", rst_oe_n, 8'h01);
    take <= 1'b0;
    w(4);
    chk("hold dropped", rails, 8'h00);
    chk("mode off", mode_on, 8'h00);
    pb_n <= 1'b0;
    w(4);
    chk("abort start", rails, 8'h0A);
    pb_n <= 1'b1;
    w(4);
    chk("aborted", rails, 8'h00);
    // the processor model takes hold only once reset is released
    frc <= 1'b0;
    take <= 1'b1;
    pb_n <= 1'b0;
    w(110);
    pb_n <= 1'b1;
    w(4);
    chk("reboot", rails, 8'h1F);
    hib_cmd <= 1'b1;
    w(4);
    chk("unforced hibernate", rails, 8'h00);
    stop_test();
  end
endmodule : rpmc_rail_power_mode_control_bench
